// ==== src/pfm_port_pin_function_mux.sv ====
// top of the port pin function mux: pads, gpio path and alternate functions
`timescale 1ns/1ps

// Function
// RULE1 - select 00 gpio, then functions one to three
// RULE2 - software never programs unimplemented select values
// RULE3 - each pin has its own configuration register
// RULE4 - pins 16-19 gpio or analog input only
// RULE5 - pins 24-25 analog, spi a selects 2,3
// RULE6 - pin 57 can e, serial l, i2c c
// RULE7 - pin 58 can f, serial m tx, i2c d
// RULE8 - pin 59 can f, serial m rx, i2c d
// RULE9 - pins 60-63 serial a and b only
// RULE10 - pins 64-71 serial c-f, timer 31-24
// RULE11 - pins 72-77 serial g-j, spi chip selects
// RULE12 - pins 98-101 spi d, i2c, analog 50-53
// RULE13 - pins 102-103 spi c, ethernet management, analog
// RULE14 - pins 104-108 timers, ethernet signals, analog
// RULE15 - reserved select leaves pin fully disconnected
module pfm_port_pin_function_mux
    import pfm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // pin configuration register access
    input wire logic cfg_wr_en,
    input wire logic [PFM_NUM_WIDTH-1:0] cfg_wr_num,
    input wire logic [1:0] cfg_wr_sel,
    output logic cfg_wr_miss,
    input wire logic [PFM_NUM_WIDTH-1:0] cfg_rd_num,
    output logic [1:0] cfg_rd_sel,
    // pads
    input wire logic [PFM_PIN_COUNT-1:0] pad_in,
    output logic [PFM_PIN_COUNT-1:0] pad_out,
    output logic [PFM_PIN_COUNT-1:0] pad_oe_n,
    // general-purpose i/o path
    input wire logic [PFM_PIN_COUNT-1:0] gpio_out,
    input wire logic [PFM_PIN_COUNT-1:0] gpio_drive,
    output logic [PFM_PIN_COUNT-1:0] gpio_in,
    // alternate functions, index 0 is function one
    input wire logic [PFM_FUNC_COUNT-1:0][PFM_PIN_COUNT-1:0] alt_out,
    input wire logic [PFM_FUNC_COUNT-1:0][PFM_PIN_COUNT-1:0] alt_drive,
    output logic [PFM_FUNC_COUNT-1:0][PFM_PIN_COUNT-1:0] alt_in
);

    // pins are handled by slot, not by gpio number: slot i stands for
    // the pin whose number is PFM_PIN_NUM[i], and every vector port
    // above is indexed by slot; a number outside the table has no
    // register, and a write to it is flagged through cfg_wr_miss

    // all state lives in one record: three synchroniser stages, the
    // filtered level and the registered outputs toward pads and
    // peripherals
    typedef struct packed {
        logic [PFM_PIN_COUNT-1:0] sync1;
        logic [PFM_PIN_COUNT-1:0] sync2;
        logic [PFM_PIN_COUNT-1:0] sync3;
        logic [PFM_PIN_COUNT-1:0] filt;
        logic [PFM_PIN_COUNT-1:0] pad_out;
        logic [PFM_PIN_COUNT-1:0] pad_oe_n;
        logic [PFM_PIN_COUNT-1:0] gpio_in;
        logic [PFM_FUNC_COUNT-1:0][PFM_PIN_COUNT-1:0] alt_in;
    } pfm_mux_state_type;

    pfm_mux_state_type state;
    pfm_mux_state_type next_state;

    pfm_cfg_if cfg ();

    // configuration access goes straight to the register store;
    // the store sits on the same clock, so nothing needs a crossing,
    // and a write lands at the edge that samples it and reaches the
    // pads one edge later
    assign cfg.wr_en = cfg_wr_en;
    assign cfg.wr_num = cfg_wr_num;
    assign cfg.wr_sel = cfg_wr_sel;
    assign cfg.rd_num = cfg_rd_num;
    assign cfg_wr_miss = cfg.wr_miss;
    assign cfg_rd_sel = cfg.rd_sel;

    // per-pin function select registers
    pfm_pin_config u_config (
        .mclk(mclk),
        .srst(srst),
        .cfg(cfg.store)
    );

    // notes for users of this block:
    // - every pad output is registered, so a peripheral sees one cycle
    //   between its drive and the pad; that cycle buys clean pad timing
    // - output-only functions drive the pad whenever they are selected
    //   and ignore their drive enable, since those peripherals have none
    // - analog functions are routed as digital inputs to alt_in; the pad
    //   is never driven while an analog function is selected
    // - a select with no function behind it is stored as written, but
    //   it leaves the pad undriven and every input reading zero
    // - a write to a pin that is not in the table changes nothing
    //   and raises cfg_wr_miss for one cycle
    // - pad pulses shorter than two cycles may be lost in the filter

    // pad steering; the capability table carries each pin's functions
    always_comb begin
        logic [1:0] sel;
        pfm_dir_type dir;
        logic reserved;
        logic drive;
        logic value;
        logic listen;
        sel = 2'h0;
        dir = PFM_DIR_NONE;
        drive = 1'b0;
        value = 1'b0;
        listen = 1'b0;
        reserved = 1'b0;
        // hold everything by default; the loop below overwrites per pin
        next_state = state;
        // pad inputs cross in; first stage feeds only the second;
        // a metastable first stage must settle before anyone looks at
        // it, and the third stage gives the agreement test its second
        // opinion before the filter follows
        next_state.sync1 = pad_in;
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        for (int i = 0; i < PFM_PIN_COUNT; i++) begin
            // a pad change counts once stages two and three agree
            if (state.sync2[i] == state.sync3[i]) begin
                next_state.filt[i] = state.sync3[i];
            end
            // RULE1 decode the select
            sel = cfg.sel[2*i +: 2];
            // the capability table gives each slot its directions;
            // the groups below name what each slot carries
            // RULE4 slots 0-3 analog only
            //   pins 16-19: function one is the analog or mux input
            // RULE5 slots 4-5 analog, spi a
            //   pins 24-25: analog in, then chip selects 2 and 3 out
            // RULE6 slot 6 receive lines
            //   pin 57: can e receive, serial l receive, i2c c data
            // RULE7 slot 7 transmit lines
            //   pin 58: can f transmit, serial m transmit, i2c d clock
            // RULE8 slot 8 receive lines
            //   pin 59: can f receive, serial m receive, i2c d data
            // RULE9 slots 9-12 serial a, b
            //   pins 60-63: tx, rx, tx, rx on function one only
            // RULE10 slots 13-20 serial, timers
            //   pins 64-71: serial c-f tx and rx, timers 31-24 two-way
            // RULE11 slots 21-26 serial, chip selects
            //   pins 72-77: serial g, h, j, then spi selects as outputs
            // RULE12 slots 27-30 spi d, i2c, analog
            //   pins 98-101: selects out, i2c two-way, analog 50-53 in
            // RULE13 slots 31-32 spi c, management
            //   pins 102-103: selects out, management clock and data
            // RULE14 slots 33-37 timers, ethernet
            //   pins 104-108: timers 7-3 two-way, ethernet, analog in
            dir = pfm_dir(PFM_CAP[i], sel);
            // RULE15 an unimplemented select has direction none;
            // catching it first keeps a stray peripheral drive off the
            // pad even if the table is later extended carelessly
            reserved = (sel != PFM_SEL_GPIO) && (dir == PFM_DIR_NONE);
            drive = 1'b0;
            value = 1'b0;
            if (reserved) begin
                drive = 1'b0; // nothing owns this pad
                value = 1'b0;
            end else if (sel == PFM_SEL_GPIO) begin
                drive = gpio_drive[i];
                value = gpio_out[i];
            end else if (dir == PFM_DIR_OUT) begin
                drive = 1'b1; // fixed outputs drive always
                value = alt_out[sel-2'h1][i];
            end else if (dir == PFM_DIR_BIDIR) begin
                drive = alt_drive[sel-2'h1][i];
                value = alt_out[sel-2'h1][i];
            end
            // RULE15 reserved leaves the pad undriven
            next_state.pad_oe_n[i] = ~drive;
            next_state.pad_out[i] = drive & value;
            // only the selected function ever sees the pad level
            next_state.gpio_in[i] = (sel == PFM_SEL_GPIO) & next_state.filt[i];
            // each function listens only while selected and able to input
            listen = !reserved
                && ((dir == PFM_DIR_IN) || (dir == PFM_DIR_BIDIR));
            for (int f = 0; f < PFM_FUNC_COUNT; f++) begin
                next_state.alt_in[f][i] =
                    (sel == 2'(f + 1)) & listen & next_state.filt[i];
            end
        end
    end

    // state register; pads start released with outputs low, so
    // nothing fights a board driver while the chip is in reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            state.sync1 <= '0;
            state.sync2 <= '0;
            state.sync3 <= '0;
            state.filt <= '0;
            state.pad_out <= '0;
            state.pad_oe_n <= '1;
            state.gpio_in <= '0;
            state.alt_in <= '0;
        end else begin
            state <= next_state;
        end
    end

    // outputs come straight from flip-flops; gpio_in and alt_in stay
    // zero unless their function owns the pin, so an idle peripheral
    // never sees stray pad activity
    assign pad_out = state.pad_out;
    assign pad_oe_n = state.pad_oe_n;
    assign gpio_in = state.gpio_in;
    assign alt_in = state.alt_in;

endmodule

// ==== src/pfm_pkg.sv ====
// package of constants, pin tables and helpers for the port pin function mux
package pfm_pkg;

    // number of multiplexed pins handled and alternate functions per pin
    localparam int PFM_PIN_COUNT = 38;
    localparam int PFM_FUNC_COUNT = 3;
    localparam int PFM_NUM_WIDTH = 7;
    localparam int PFM_SLOT_WIDTH = 6;

    // function-select encodings
    localparam logic [1:0] PFM_SEL_GPIO = 2'h0;
    localparam logic [1:0] PFM_SEL_FUNC1 = 2'h1;
    localparam logic [1:0] PFM_SEL_FUNC2 = 2'h2;
    localparam logic [1:0] PFM_SEL_FUNC3 = 2'h3;
    localparam logic [1:0] PFM_SEL_RESET = 2'h0;

    // field layout of a capability word: two bits per alternate function
    localparam int PFM_CAP_FIELD = 2;

    // direction an alternate function gives the pad
    typedef enum logic [1:0] {
        PFM_DIR_NONE,
        PFM_DIR_IN,
        PFM_DIR_OUT,
        PFM_DIR_BIDIR
    } pfm_dir_type;

    // general-purpose number of each handled pin, by slot
    localparam logic [6:0] PFM_PIN_NUM [PFM_PIN_COUNT] = '{
        7'h10, 7'h11, 7'h12, 7'h13, 7'h18, 7'h19,
        7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F,
        7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47,
        7'h48, 7'h49, 7'h4A, 7'h4B, 7'h4C, 7'h4D,
        7'h62, 7'h63, 7'h64, 7'h65, 7'h66, 7'h67,
        7'h68, 7'h69, 7'h6A, 7'h6B, 7'h6C
    };

    // per slot {func3, func2, func1} directions: 0 none 1 in 2 out 3 bidir
    localparam logic [5:0] PFM_CAP [PFM_PIN_COUNT] = '{
        6'h01, 6'h01, 6'h01, 6'h01, 6'h09, 6'h09,
        6'h35, 6'h3A, 6'h35, 6'h02, 6'h01, 6'h02, 6'h01,
        6'h0E, 6'h0D, 6'h0E, 6'h0D, 6'h0E, 6'h0D, 6'h0E, 6'h0D,
        6'h0A, 6'h09, 6'h0A, 6'h09, 6'h0A, 6'h09,
        6'h1E, 6'h1E, 6'h1E, 6'h1E, 6'h1A, 6'h1E,
        6'h17, 6'h17, 6'h1B, 6'h17, 6'h1B
    };

    // direction of a pin for a given select; gpio is always two-way
    function automatic pfm_dir_type pfm_dir(input logic [5:0] cap,
                                            input logic [1:0] sel);
        pfm_dir_type d;
        d = PFM_DIR_BIDIR;
        unique case (sel)
            PFM_SEL_GPIO: d = PFM_DIR_BIDIR;
            PFM_SEL_FUNC1: d = pfm_dir_type'(cap[1:0]);
            PFM_SEL_FUNC2: d = pfm_dir_type'(cap[3:2]);
            PFM_SEL_FUNC3: d = pfm_dir_type'(cap[5:4]);
        endcase
        return d;
    endfunction

    // slot lookup by pin number: bit 6 is a hit, bits 5:0 the slot
    function automatic logic [6:0] pfm_slot(input logic [6:0] num);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < PFM_PIN_COUNT; i++) begin
            if (PFM_PIN_NUM[i] == num) begin
                r = {1'b1, 6'(i)};
            end
        end
        return r;
    endfunction

endpackage

// ==== src/pfm_cfg_if.sv ====
// interface between the pin mux and its per-pin configuration store
`timescale 1ns/1ps
interface pfm_cfg_if;
    import pfm_pkg::*;

    logic wr_en;
    logic [PFM_NUM_WIDTH-1:0] wr_num;
    logic [1:0] wr_sel;
    logic wr_miss;
    logic [PFM_NUM_WIDTH-1:0] rd_num;
    logic [1:0] rd_sel;
    logic [2*PFM_PIN_COUNT-1:0] sel;

    modport store (
        input wr_en,
        input wr_num,
        input wr_sel,
        input rd_num,
        output wr_miss,
        output rd_sel,
        output sel
    );

    modport mux (
        output wr_en,
        output wr_num,
        output wr_sel,
        output rd_num,
        input wr_miss,
        input rd_sel,
        input sel
    );
endinterface

// ==== src/pfm_pin_config.sv ====
// per-pin configuration registers holding each pin's function select
`timescale 1ns/1ps
module pfm_pin_config
    import pfm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // configuration access
    pfm_cfg_if.store cfg
);

    typedef struct packed {
        logic [2*PFM_PIN_COUNT-1:0] sel;
        logic [1:0] rd_sel;
        logic wr_miss;
    } pfm_cfg_state_type;

    pfm_cfg_state_type state;
    pfm_cfg_state_type next_state;

    // write selects one pin's register by its gpio number
    always_comb begin
        logic [6:0] wr_hit;
        logic [6:0] rd_hit;
        wr_hit = pfm_slot(cfg.wr_num);
        rd_hit = pfm_slot(cfg.rd_num);
        next_state = state;
        next_state.wr_miss = 1'b0;
        // RULE3 one register per pin
        if (cfg.wr_en) begin
            if (wr_hit[6]) begin
                next_state.sel[2*wr_hit[5:0] +: 2] = cfg.wr_sel;
            end else begin
                next_state.wr_miss = 1'b1; // number not multiplexed here
            end
        end
        // read-back of the stored select; unknown numbers read zero
        next_state.rd_sel = rd_hit[6] ? state.sel[2*rd_hit[5:0] +: 2]
                                      : 2'h0;
    end

    // state register; every pin comes up as general-purpose i/o
    always_ff @(posedge mclk) begin
        if (srst) begin
            state.sel <= {PFM_PIN_COUNT{PFM_SEL_RESET}};
            state.rd_sel <= 2'h0;
            state.wr_miss <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign cfg.sel = state.sel;
    assign cfg.rd_sel = state.rd_sel;
    assign cfg.wr_miss = state.wr_miss;

endmodule

// ==== verification/pfm_mux_properties.sv ====
// checker for routing, config port and reset of the pin mux
`timescale 1ns/1ps
module pfm_mux_properties
    import pfm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // configuration port
    input wire logic cfg_wr_en,
    input wire logic [PFM_NUM_WIDTH-1:0] cfg_wr_num,
    input wire logic [1:0] cfg_wr_sel,
    input wire logic cfg_wr_miss,
    input wire logic [PFM_NUM_WIDTH-1:0] cfg_rd_num,
    input wire logic [1:0] cfg_rd_sel,
    // pads and function paths
    input wire logic [PFM_PIN_COUNT-1:0] pad_in,
    input wire logic [PFM_PIN_COUNT-1:0] pad_out,
    input wire logic [PFM_PIN_COUNT-1:0] pad_oe_n,
    input wire logic [PFM_PIN_COUNT-1:0] gpio_out,
    input wire logic [PFM_PIN_COUNT-1:0] gpio_drive,
    input wire logic [PFM_PIN_COUNT-1:0] gpio_in,
    input wire logic [PFM_FUNC_COUNT-1:0][PFM_PIN_COUNT-1:0] alt_out,
    input wire logic [PFM_FUNC_COUNT-1:0][PFM_PIN_COUNT-1:0] alt_drive,
    input wire logic [PFM_FUNC_COUNT-1:0][PFM_PIN_COUNT-1:0] alt_in
);
    localparam int N = PFM_PIN_COUNT;
    logic [1:0] sh [N];
    logic [N-1:0] e_out, e_oen, e_gin, hit;
    logic [PFM_FUNC_COUNT-1:0][N-1:0] e_ain;
    logic [1:0] e_rd, d;
    logic en;

    // shadow selects, kept apart from the design's own store
    always_ff @(posedge mclk)
        for (int i = 0; i < N; i++)
            if (srst) sh[i] <= 2'h0;
            else if (cfg_wr_en && hit[i]) sh[i] <= cfg_wr_sel;

    // expected routing; reserved selects give direction none
    always_comb begin
        e_rd = 2'h0;
        e_ain = '0;
        for (int i = 0; i < N; i++) begin
            hit[i] = PFM_PIN_NUM[i] == cfg_wr_num;
            if (PFM_PIN_NUM[i] == cfg_rd_num) e_rd = sh[i];
            d = sh[i] == 2'h0 ? 2'h3 : 2'(PFM_CAP[i] >> {sh[i] - 2'h1, 1'b0});
            en = sh[i] == 2'h0 ? gpio_drive[i] : alt_drive[sh[i] - 2'h1][i];
            en = d == 2'h2 || (d == 2'h3 && en);
            e_oen[i] = !en;
            e_out[i] = en && (sh[i] == 2'h0 ? gpio_out[i]
                : alt_out[sh[i] - 2'h1][i]);
            e_gin[i] = sh[i] == 2'h0;
            if (sh[i] != 2'h0) e_ain[sh[i] - 2'h1][i] = d[0];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_pad_level: assert property (
        !$past(srst) |-> pad_out == $past(e_out)) else $error("pad level");
    chk_pad_enable: assert property (
        !$past(srst) |-> pad_oe_n == $past(e_oen)) else $error("pad enable");
    chk_miss_flag: assert property (
        cfg_wr_en |=> cfg_wr_miss == $past(hit == '0)) else $error("miss");
    chk_read_back: assert property (
        !$past(srst) |-> cfg_rd_sel == $past(e_rd)) else $error("read back");
    chk_gpio_gated: assert property (
        !$past(srst) |-> (gpio_in & ~$past(e_gin)) == '0)
        else $error("gpio input");
    chk_alt_gated: assert property (
        !$past(srst) |-> (alt_in & ~$past(e_ain)) == '0)
        else $error("alt input");
    chk_input_follow: assert property (
        (!$past(srst) && $stable(pad_in[0]) && e_gin[0])[*6]
        |-> gpio_in[0] == pad_in[0]) else $error("input filter");
    chk_reset_quiet: assert property (
        @(posedge mclk) disable iff (1'b0) srst |=> &pad_oe_n
        && pad_out == '0 && gpio_in == '0 && alt_in == '0)
        else $error("reset state");
endmodule

// ==== verification/pfm_pad_model.sv ====
// pad and board model: resolves each pad from block and far driver
`timescale 1ns/1ps
module pfm_pad_model
    import pfm_pkg::*;
(
    // clock
    input wire logic mclk,
    // block side and far driver
    input wire logic [PFM_PIN_COUNT-1:0] pad_out,
    input wire logic [PFM_PIN_COUNT-1:0] pad_oe_n,
    input wire logic [PFM_PIN_COUNT-1:0] ext_lvl,
    input wire logic [PFM_PIN_COUNT-1:0] ext_en,
    // level seen at the pad
    output logic [PFM_PIN_COUNT-1:0] pad_in
);
    logic [PFM_PIN_COUNT-1:0] wander = '0;
    // an undriven pad wanders so a stale level never reads as input
    always_ff @(posedge mclk) wander <= ~wander;
    assign pad_in = (~pad_oe_n & pad_out) | (ext_en & ext_lvl)
        | (pad_oe_n & ~ext_en & wander);
endmodule

// ==== verification/test_port_pin_function_mux.sv ====
// self-checking bench for the port pin function mux
`timescale 1ns/1ps
module test_port_pin_function_mux;
    import pfm_pkg::*;
    localparam int N = PFM_PIN_COUNT;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cfg_wr_en = 1'b0;
    logic [6:0] cfg_wr_num = 7'h00;
    logic [1:0] cfg_wr_sel = 2'h0;
    logic [6:0] cfg_rd_num = 7'h00;
    logic cfg_wr_miss, miss;
    logic [1:0] cfg_rd_sel;
    logic [N-1:0] pad_in, pad_out, pad_oe_n, gpio_in;
    logic [N-1:0] gpio_out = '0, gpio_drive = '0, ext_lvl = '0, ext_en = '0;
    logic [2:0][N-1:0] alt_out = '0, alt_drive = '0, alt_in;
    int err_total = 0;
    int samples_checked = 0;

    pfm_port_pin_function_mux i_dut (.*);
    pfm_pad_model i_pad (.mclk, .pad_out, .pad_oe_n, .ext_lvl, .ext_en,
        .pad_in);

    initial forever #10 mclk = ~mclk;

    task automatic chk(input string what, input logic [1:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // one-cycle write strobe; the read port follows the same pin
    task automatic wr(input logic [6:0] num, input logic [1:0] sel);
        @(posedge mclk);
        cfg_wr_en <= 1'b1;
        cfg_wr_num <= num;
        cfg_wr_sel <= sel;
        cfg_rd_num <= num;
        @(posedge mclk);
        cfg_wr_en <= 1'b0;
        @(negedge mclk);
        miss = cfg_wr_miss;
    endtask

    // each function select (1 to 3) in turn: listen with far driver, then let function drive
    // reserved selects written here only to prove pad isolation
    task automatic probe(input int s, input logic [6:0] n, logic [5:0] dirs);
        logic [1:0] d;
        for (int f = 0; f < 3; f++) begin
            d = dirs[2*f+:2];
            wr(n, 2'(f + 1));
            @(posedge mclk);
            alt_out[f][s] <= 1'b1;
            ext_en[s] <= 1'b1;
            ext_lvl[s] <= 1'b1;
            repeat (7) @(posedge mclk);
            @(negedge mclk);
            chk("miss", miss, 2'h0);
            chk("rd_sel", cfg_rd_sel, 2'(f + 1));
            chk("listen_oe", pad_oe_n[s], d != 2'h2);
            chk("alt_in", alt_in[f][s], d[0]);
            chk("gpio_in", gpio_in[s], 2'h0);
            @(posedge mclk);
            alt_drive[f][s] <= 1'b1;
            ext_en[s] <= 1'b0;
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            chk("drive_oe", pad_oe_n[s], !d[1]);
            chk("pad_out", pad_out[s], d[1]);
            @(posedge mclk);
            alt_drive <= '0;
            alt_out <= '0;
        end
    endtask

    // gpio path on pin 16 straight out of reset, then an unknown pin
    task automatic t_gpio_miss;
        @(posedge mclk);
        gpio_drive[0] <= 1'b1;
        gpio_out[0] <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("gpio_oe", pad_oe_n[0], 2'h0);
        chk("gpio_out", pad_out[0], 2'h1);
        @(posedge mclk);
        gpio_drive[0] <= 1'b0;
        ext_en[0] <= 1'b1;
        ext_lvl[0] <= 1'b1;
        repeat (7) @(posedge mclk);
        @(negedge mclk);
        chk("gpio_in", gpio_in[0], 2'h1);
        wr(7'h14, 2'h1);
        chk("miss", miss, 2'h1);
    endtask

    // analog, spi, can, serial and i2c pins
    task automatic t_low_pins;
        probe(0, 7'h10, {2'h0, 2'h0, 2'h1});
        probe(4, 7'h18, {2'h0, 2'h2, 2'h1});
        probe(6, 7'h39, {2'h3, 2'h1, 2'h1});
        probe(7, 7'h3A, {2'h3, 2'h2, 2'h2});
        probe(8, 7'h3B, {2'h3, 2'h1, 2'h1});
        probe(9, 7'h3C, {2'h0, 2'h0, 2'h2});
        probe(12, 7'h3F, {2'h0, 2'h0, 2'h1});
    endtask

    // timer, chip-select, ethernet and analog pins
    task automatic t_high_pins;
        probe(13, 7'h40, {2'h0, 2'h3, 2'h2});
        probe(20, 7'h47, {2'h0, 2'h3, 2'h1});
        probe(21, 7'h48, {2'h0, 2'h2, 2'h2});
        probe(26, 7'h4D, {2'h0, 2'h2, 2'h1});
        probe(27, 7'h62, {2'h1, 2'h3, 2'h2});
        probe(31, 7'h66, {2'h1, 2'h2, 2'h2});
        probe(32, 7'h67, {2'h1, 2'h3, 2'h2});
        probe(33, 7'h68, {2'h1, 2'h1, 2'h3});
        probe(37, 7'h6C, {2'h1, 2'h2, 2'h3});
    endtask

    // later writes left pin 57 alone; a mid-run reset clears it
    task automatic t_isolate_reset;
        @(posedge mclk);
        cfg_rd_num <= 7'h39;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("isolate", cfg_rd_sel, 2'h3);
        @(posedge mclk);
        srst <= 1'b1;
        gpio_drive <= '0;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        chk("rst_oe", &pad_oe_n, 2'h1);
        chk("rst_sel", cfg_rd_sel, 2'h0);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        t_gpio_miss;
        t_low_pins;
        t_high_pins;
        t_isolate_reset;
        conclude;
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        conclude;
    end
endmodule

bind pfm_port_pin_function_mux pfm_mux_properties i_chk (.*);
